// *** include/tmg_pkg.sv ***
/*
 * tmg_pkg: shared constants, field layouts and types of the timer mode
 * and output gate block.
 * Assumes: included before every design file of the block.
 */
package tmg_pkg;

   // ==========================================================
   // register indices (word address on the bus, byte address is 4x)
   localparam logic [31:0] IDX_FUNC_CTRL = 32'h40042A66;
   localparam logic [31:0] IDX_OUT_DISABLE = 32'h40042A67;
   localparam logic [31:0] IDX_CUTOFF = 32'h40042A68;
   localparam logic [31:0] IDX_COUNT_RUN = 32'h40042A63;

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_FUNC_CTRL = 8'h80;
   localparam logic [7:0] RST_OUT_DISABLE = 8'hFF;
   localparam logic [7:0] RST_CUTOFF = 8'h00;
   localparam logic [1:0] RST_COUNT_RUN = 2'h0;

   // ==========================================================
   // field positions
   localparam int FC_THREE_PHASE = 7;
   localparam int FC_EXT_CLK = 6;
   localparam int FC_INV_POL = 3;
   localparam int FC_POS_POL = 2;
   localparam int FC_CMD_HI = 1;
   localparam int FC_CMD_LO = 0;
   localparam int CO_PIN_EN = 7;
   localparam int CO_FLAG = 0;
   localparam int RUN_CH0 = 0;
   localparam int RUN_CH1 = 1;

   // pin order inside the disable register
   localparam int PIN_CH0_A = 0;
   localparam int NUM_PINS = 8;

   // pins that carry the inverted phase in the pwm modes (d1, c1, d0)
   localparam logic [7:0] INV_PHASE_PINS = 8'hC8;

   // ==========================================================
   // combined mode field encodings
   localparam logic [1:0] CMD_TIMER_OR_THREE_PHASE_MODE_SELECT = 2'h0;
   localparam logic [1:0] CMD_RESET_SYNC = 2'h1;
   localparam logic [1:0] CMD_COMP_UNDERFLOW = 2'h2;
   localparam logic [1:0] CMD_COMP_MATCH = 2'h3;

   typedef enum logic [2:0] {
      TMG_MODE_TIMER = 3'b000,
      TMG_MODE_THREE_PHASE_MODE_SELECT = 3'b001,
      TMG_MODE_RESET_SYNC = 3'b010,
      TMG_MODE_COMP_UNDERFLOW = 3'b011,
      TMG_MODE_COMP_MATCH = 3'b100
   } tmg_mode_t;

   // function control register as a carrier
   typedef struct packed {
      logic three_phase_mode_select;
      logic external_clock_select;
      logic [1:0] unused;
      logic inverted_phase_polarity;
      logic positive_phase_polarity;
      logic combined_mode_hi;
      logic combined_mode_lo;
   } tmg_func_ctrl_t;

   // per-pin gate controls
   typedef struct packed {
      logic enable;
      logic pwm_mode;
      logic polarity;
      logic cutoff;
   } tmg_gate_ctrl_t;

endpackage

// *** hdl/tmg_sync2.sv ***
/*
 * tmg_sync2: two flip-flop level synchroniser for pin inputs.
 * Assumes: asynchronous input, synchronous active-low reset.
 */
`timescale 1ns/1ps
module tmg_sync2 #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic async_i,
   output logic sync_o
);
   logic meta_q;
   logic sync_q;

   // first stage is read only by the second stage
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule

// *** hdl/tmg_pin_gate.sv ***
/*
 * tmg_pin_gate: registered output gate of one timer pin.
 * Assumes: waveform_i is the counter's active-high pulse for the pin.
 */
`timescale 1ns/1ps
module tmg_pin_gate (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire tmg_pkg::tmg_gate_ctrl_t ctrl_i,
   input wire logic waveform_i,
   output logic pin_o,
   output logic pin_oe_o
);
   logic active;
   logic level;

   // cutoff drops the active phase, leaving the pin at its idle level
   always_comb begin
      active = waveform_i & ~ctrl_i.cutoff;
      if (ctrl_i.pwm_mode) begin
         level = ctrl_i.polarity ? active : ~active;
      end else begin
         level = active;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         pin_o <= 1'b0;
         pin_oe_o <= 1'b0;
      end else begin
         pin_o <= level;
         pin_oe_o <= ctrl_i.enable;
      end
   end
endmodule

// *** hdl/tmg_top.sv ***
/*
 * tmg_top: mode selection and output gating of a two-channel timer.
 * Holds the function control, output disable, forced cutoff and count
 * run registers behind an Avalon-MM slave, decodes the operating mode
 * and gates eight timer pins.
 * Assumes: counters elsewhere supply per-pin waveforms on ref_clk_i;
 * the cutoff pin and external clock pin are asynchronous.
 */
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module tmg_top #(
   parameter int ADDR_W = 32,
   parameter logic [7:0] INV_PINS = tmg_pkg::INV_PHASE_PINS
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // counter side, same clock
   input wire logic [7:0] pin_pwm_function_select_i,
   input wire logic [7:0] waveform_i,
   input wire logic event_cutoff_i,
   // pins
   input wire logic external_interrupt_pin_zero_i,
   input wire logic ext_clk_pin_i,
   output logic [7:0] pin_o,
   output logic [7:0] pin_oe_o,
   // to the counters
   output tmg_pkg::tmg_mode_t mode_o,
   output logic ext_clk_o,
   output logic ch0_count_run_o,
   output logic ch1_count_run_o,
   output logic xfer_on_underflow_o,
   output logic xfer_on_match_o,
   output logic cutoff_o
);

   // ==========================================================
   // register state
   tmg_pkg::tmg_func_ctrl_t func_ctrl_q;
   logic [7:0] out_disable_q;
   logic cutoff_pin_enable_q;
   logic cutoff_flag_q;
   logic [1:0] count_run_q;

   // ==========================================================
   // pin synchronisers
   logic intp_sync;
   logic ext_clk_sync;

   tmg_sync2 #(
      .RST_VAL(1'b1)
   ) u_sync_intp (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .async_i(external_interrupt_pin_zero_i),
      .sync_o(intp_sync)
   );

   tmg_sync2 #(
      .RST_VAL(1'b0)
   ) u_sync_extclk (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .async_i(ext_clk_pin_i),
      .sync_o(ext_clk_sync)
   );

   // ==========================================================
   // bus access decode
   logic access_done;
   logic wr_fire;
   logic hit_func;
   logic hit_dis;
   logic hit_cut;
   logic hit_run;
   logic [7:0] wbyte;
   logic [7:0] rbyte;
   logic waitrequest_q;
   logic [31:0] readdata_q;

   // a request completes on the edge where waitrequest is sampled low
   assign access_done = (avs_read_i | avs_write_i) & ~waitrequest_q;
   assign wr_fire = avs_write_i & ~waitrequest_q & avs_byteenable_i[0];
   assign wbyte = avs_writedata_i[7:0];
   assign hit_func = (32'(avs_address_i) == tmg_pkg::IDX_FUNC_CTRL);
   assign hit_dis = (32'(avs_address_i) == tmg_pkg::IDX_OUT_DISABLE);
   assign hit_cut = (32'(avs_address_i) == tmg_pkg::IDX_CUTOFF);
   assign hit_run = (32'(avs_address_i) == tmg_pkg::IDX_COUNT_RUN);

   always_comb begin
      rbyte = 8'h00;
      if (hit_func) begin
         rbyte = func_ctrl_q;
         rbyte[5:4] = 2'h0;
      end else if (hit_dis) begin
         rbyte = out_disable_q;
      end else if (hit_cut) begin
         rbyte[tmg_pkg::CO_PIN_EN] = cutoff_pin_enable_q;
         rbyte[tmg_pkg::CO_FLAG] = cutoff_flag_q;
      end else if (hit_run) begin
         rbyte[tmg_pkg::RUN_CH1:tmg_pkg::RUN_CH0] = count_run_q;
      end
   end

   // one wait state: waitrequest drops the cycle after the request
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         waitrequest_q <= 1'b1;
      end else if (access_done) begin
         waitrequest_q <= 1'b1;
      end else if (avs_read_i | avs_write_i) begin
         waitrequest_q <= 1'b0;
      end
   end

   // unmapped addresses read zero
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         readdata_q <= 32'h00000000;
      end else if (avs_read_i & waitrequest_q) begin
         readdata_q <= {24'h000000, rbyte};
      end
   end

   assign avs_waitrequest_o = waitrequest_q;
   assign avs_readdata_o = readdata_q;

   // ==========================================================
   // function control register
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         func_ctrl_q <= tmg_pkg::RST_FUNC_CTRL;
      end else if (wr_fire & hit_func) begin
         // writing the mode field while running is not blocked
         func_ctrl_q <= wbyte;
         func_ctrl_q.unused <= 2'h0;
      end
   end

   // ==========================================================
   // output disable register
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         out_disable_q <= tmg_pkg::RST_OUT_DISABLE;
      end else if (wr_fire & hit_dis) begin
         out_disable_q <= wbyte;
      end
   end

   // ==========================================================
   // count run register
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         count_run_q <= tmg_pkg::RST_COUNT_RUN;
      end else if (wr_fire & hit_run) begin
         count_run_q <= wbyte[tmg_pkg::RUN_CH1:tmg_pkg::RUN_CH0];
      end
   end

   // ==========================================================
   // forced cutoff
   logic counters_stopped;
   logic cutoff_event;
   logic flag_wr_one;
   logic flag_wr_zero;

   assign counters_stopped = (count_run_q == 2'h0);
   assign cutoff_event = (cutoff_pin_enable_q & ~intp_sync)
                         | event_cutoff_i;
   assign flag_wr_one = wr_fire & hit_cut & wbyte[tmg_pkg::CO_FLAG];
   assign flag_wr_zero = wr_fire & hit_cut & ~wbyte[tmg_pkg::CO_FLAG];

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         cutoff_pin_enable_q <= tmg_pkg::RST_CUTOFF[tmg_pkg::CO_PIN_EN];
      end else if (wr_fire & hit_cut) begin
         cutoff_pin_enable_q <= wbyte[tmg_pkg::CO_PIN_EN];
      end
   end

   // set wins over clear; a clear while counting is dropped
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         cutoff_flag_q <= tmg_pkg::RST_CUTOFF[tmg_pkg::CO_FLAG];
      end else if (cutoff_event | flag_wr_one) begin
         cutoff_flag_q <= 1'b1;
      end else if (flag_wr_zero & counters_stopped) begin
         cutoff_flag_q <= 1'b0;
      end
   end

   // ==========================================================
   // mode decode
   tmg_pkg::tmg_mode_t mode_d;
   logic [1:0] cmd;
   logic pwm_mode;

   assign cmd = {func_ctrl_q.combined_mode_hi, func_ctrl_q.combined_mode_lo};

   always_comb begin
      case (cmd)
         tmg_pkg::CMD_TIMER_OR_THREE_PHASE_MODE_SELECT: begin
            // three-phase select only matters here
            if (func_ctrl_q.three_phase_mode_select) begin
               mode_d = tmg_pkg::TMG_MODE_TIMER;
            end else begin
               mode_d = tmg_pkg::TMG_MODE_THREE_PHASE_MODE_SELECT;
            end
         end
         tmg_pkg::CMD_RESET_SYNC: begin
            mode_d = tmg_pkg::TMG_MODE_RESET_SYNC;
         end
         tmg_pkg::CMD_COMP_UNDERFLOW: begin
            // reload waits for the second counter to wrap
            mode_d = tmg_pkg::TMG_MODE_COMP_UNDERFLOW;
         end
         tmg_pkg::CMD_COMP_MATCH: begin
            // reload on the first counter's period match
            mode_d = tmg_pkg::TMG_MODE_COMP_MATCH;
         end
         default: begin
            mode_d = tmg_pkg::TMG_MODE_TIMER;
         end
      endcase
   end

   // pin pwm selection is overridden by any nonzero mode field
   assign pwm_mode = (cmd != tmg_pkg::CMD_TIMER_OR_THREE_PHASE_MODE_SELECT);

   // ==========================================================
   // registered control outputs
   // mode follows the field one cycle late; counters see a clean level
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         mode_o <= tmg_pkg::TMG_MODE_TIMER;
      end else begin
         mode_o <= mode_d;
      end
   end

   // reload trigger selection, only one can be high at a time
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         xfer_on_underflow_o <= 1'b0;
         xfer_on_match_o <= 1'b0;
      end else begin
         xfer_on_underflow_o <= (mode_d == tmg_pkg::TMG_MODE_COMP_UNDERFLOW);
         xfer_on_match_o <= (mode_d == tmg_pkg::TMG_MODE_COMP_MATCH);
      end
   end

   // external clock passes only when selected outside three-phase mode
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         ext_clk_o <= 1'b0;
      end else begin
         ext_clk_o <= ext_clk_sync & func_ctrl_q.external_clock_select
                      & (mode_d != tmg_pkg::TMG_MODE_THREE_PHASE_MODE_SELECT);
      end
   end

   // run flags pass straight on; cutoff does not stop the counters
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         ch0_count_run_o <= 1'b0;
         ch1_count_run_o <= 1'b0;
      end else begin
         ch0_count_run_o <= count_run_q[tmg_pkg::RUN_CH0];
         ch1_count_run_o <= count_run_q[tmg_pkg::RUN_CH1];
      end
   end

   // cutoff copy lines up with the gated pins, both one cycle late
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         cutoff_o <= 1'b0;
      end else begin
         cutoff_o <= cutoff_flag_q;
      end
   end

   // ==========================================================
   // pin gates
   // in timer mode the per-pin pwm select decides
   // whether the cutoff flag drops the counter waveform
   genvar gi;
   generate
      for (gi = 0; gi < tmg_pkg::NUM_PINS; gi++) begin : g_pin
         tmg_pkg::tmg_gate_ctrl_t ctrl;
         assign ctrl.enable = ~out_disable_q[gi];
         assign ctrl.pwm_mode = pwm_mode;
         // polarity 0: idle high, active low
         assign ctrl.polarity = INV_PINS[gi] ? func_ctrl_q.inverted_phase_polarity
                                             : func_ctrl_q.positive_phase_polarity;
         // in timer mode plain compare outputs are not pulses and are not cut
         assign ctrl.cutoff = cutoff_flag_q & (pwm_mode
                              | pin_pwm_function_select_i[gi]
                              | (mode_d == tmg_pkg::TMG_MODE_THREE_PHASE_MODE_SELECT));

         tmg_pin_gate u_gate (
            .ref_clk_i(ref_clk_i),
            .resetn_i(resetn_i),
            .ctrl_i(ctrl),
            .waveform_i(waveform_i[gi]),
            .pin_o(pin_o[gi]),
            .pin_oe_o(pin_oe_o[gi])
         );
      end
   endgenerate

endmodule

// *** tb/tmg_top_asserts.sv ***
/* tmg_top_asserts: port-level checks of the timer mode and output gate.
   Assumes: bound into tmg_top, one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module tmg_top_asserts #(
   parameter int ADDR_W = 32
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   input wire logic [7:0] pin_pwm_function_select_i,
   input wire logic event_cutoff_i,
   input wire logic external_interrupt_pin_zero_i,
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe_o,
   input wire tmg_pkg::tmg_mode_t mode_o,
   input wire logic xfer_on_underflow_o,
   input wire logic xfer_on_match_o,
   input wire logic cutoff_o
);
   // ==========
   // shadow of accepted writes
   logic wr_ok, wr_fn, wr_ds, wr_ct, clr_ok, pin_en_q;
   logic [2:0] mode_q;
   logic [7:0] dis_q;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   assign wr_fn = wr_ok && avs_address_i == ADDR_W'(tmg_pkg::IDX_FUNC_CTRL);
   assign wr_ds = wr_ok && avs_address_i == ADDR_W'(tmg_pkg::IDX_OUT_DISABLE);
   assign wr_ct = wr_ok && avs_address_i == ADDR_W'(tmg_pkg::IDX_CUTOFF);
   assign clr_ok = wr_ct && !avs_writedata_i[0];
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         mode_q <= 3'h0;
      end else if (wr_fn) begin
         // zero field defers to the three-phase bit, others map one up
         mode_q <= (avs_writedata_i[1:0] == 2'h0) ? {2'h0, !avs_writedata_i[7]}
            : {1'b0, avs_writedata_i[1:0]} + 3'h1;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         dis_q <= 8'hFF;
         pin_en_q <= 1'b0;
      end else begin
         if (wr_ds) dis_q <= avs_writedata_i[7:0];
         if (wr_ct) pin_en_q <= avs_writedata_i[7];
      end
   end
   // ==========
   // assertions
   ack_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   ack_next_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o) else $error("access not answered in the next cycle");
   reset_state_a: assert property ($rose(resetn_i) |-> avs_waitrequest_o &&
      pin_oe_o == 8'h00 && mode_o == tmg_pkg::TMG_MODE_TIMER) else $error("bad reset state");
   mode_dec_a: assert property (wr_fn |=> ##1 mode_o == mode_q)
      else $error("mode does not follow the control write");
   xfer_sel_a: assert property (xfer_on_underflow_o == (mode_q == 3'h3)
      && xfer_on_match_o == (mode_q == 3'h4) || $changed(mode_q))
      else $error("reload trigger selection wrong");
   oe_mask_a: assert property (wr_ds |=> ##1 pin_oe_o == ~dis_q)
      else $error("pin enables do not follow the disable mask");
   event_cut_a: assert property (event_cutoff_i |=> ##1 cutoff_o)
      else $error("event did not force cutoff");
   cut_sticky_a: assert property ($fell(cutoff_o) |-> $past(clr_ok, 2))
      else $error("cutoff cleared without a write of zero");
   sw_cut_a: assert property (wr_ct && avs_writedata_i[0] |=> ##1 cutoff_o)
      else $error("write of one did not force cutoff");
   pin_cut_a: assert property ((pin_en_q && !external_interrupt_pin_zero_i)[*5]
      |-> cutoff_o) else $error("low cutoff pin ignored");
   cut_idle_a: assert property (cutoff_o && mode_o == tmg_pkg::TMG_MODE_TIMER
      |-> (pin_o & $past(pin_pwm_function_select_i)) == 8'h00)
      else $error("pwm pin active under cutoff");
   cover property (event_cutoff_i ##2 cutoff_o);
   cover property (mode_o == tmg_pkg::TMG_MODE_COMP_MATCH);
   cover property (avs_read_i && !avs_waitrequest_o);
endmodule

bind tmg_top tmg_top_asserts #(.ADDR_W(ADDR_W)) u_asserts (
   .ref_clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
   .avs_byteenable_i, .avs_waitrequest_o, .pin_pwm_function_select_i, .event_cutoff_i,
   .external_interrupt_pin_zero_i, .pin_o, .pin_oe_o, .mode_o, .xfer_on_underflow_o,
   .xfer_on_match_o, .cutoff_o
);

// *** tb/tmg_stage.sv ***
/* tmg_stage: far side model, power stage loads and the cutoff pin source.
   Assumes: every timer pin and the cutoff pin carry a pull-up. */
`timescale 1ns/1ps
module tmg_stage (
   input wire logic trip_i,
   input wire logic [7:0] pin_i,
   input wire logic [7:0] pin_oe_i,
   output logic [7:0] load_o,
   output logic cut_pin_o
);
   // undriven pins float to the pull-up, never the last driven level
   assign load_o = (pin_i & pin_oe_i) | ~pin_oe_i;
   // fault source pulls low, idles high
   assign cut_pin_o = !trip_i;
endmodule

// *** tb/tmg_top_tb.sv ***
/* tmg_top_tb: self-checking bench for the timer mode and output gate.
   Assumes: tmg_pkg compiled first; checker bound; stage model on the pins. */
`timescale 1ns/1ps
module tmg_top_tb;
   localparam logic [31:0] FN = tmg_pkg::IDX_FUNC_CTRL;
   localparam logic [31:0] DS = tmg_pkg::IDX_OUT_DISABLE;
   localparam logic [31:0] CT = tmg_pkg::IDX_CUTOFF;
   localparam logic [31:0] RN = tmg_pkg::IDX_COUNT_RUN;
   logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, evt = 1'b0, trip = 1'b0, extc = 1'b0;
   logic wreq, ext_o, run0, run1, xu, xm, cut, cpin;
   logic [31:0] addr = '0, wdata = '0, rdata, q;
   logic [3:0] be = 4'hF;
   logic [7:0] psel = 8'h00, wave = 8'h00, pin, oe, load, pm;
   logic [2:0] em;
   tmg_pkg::tmg_mode_t mode;
   int fail_count = 0, tests_run = 0, i;

   tmg_top dut (
      .ref_clk_i(clk), .resetn_i(rstn), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .pin_pwm_function_select_i(psel),
      .waveform_i(wave), .event_cutoff_i(evt), .external_interrupt_pin_zero_i(cpin),
      .ext_clk_pin_i(extc), .pin_o(pin), .pin_oe_o(oe), .mode_o(mode), .ext_clk_o(ext_o),
      .ch0_count_run_o(run0), .ch1_count_run_o(run1), .xfer_on_underflow_o(xu),
      .xfer_on_match_o(xm), .cutoff_o(cut)
   );
   tmg_stage stage (.trip_i(trip), .pin_i(pin), .pin_oe_i(oe), .load_o(load), .cut_pin_o(cpin));

   always #5 clk = ~clk;

   // ==========
   // checking and bus tasks
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   // request held until waitrequest is sampled low, then released
   task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d,
      input logic [3:0] b);
      int n;
      @(posedge clk);
      addr <= a;
      wdata <= {24'h000000, d};
      be <= b;
      rd <= !w;
      wr <= w;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (!wreq) break;
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n == 20) begin
         fail_count++;
         tally_and_finish();
      end
   endtask
   task automatic wr8(input logic [31:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, 4'hF);
      chk(q, {24'h000000, e});
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // ==========
   // scenarios
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      rdc(FN, 8'h80);
      rdc(DS, 8'hFF);
      rdc(CT, 8'h00);
      bus(1'b1, DS, 8'h00, 4'hE);
      rdc(DS, 8'hFF);
      wr8(32'h40042A70, 8'h5A);
      rdc(32'h40042A70, 8'h00);
      $display("reset and refusal test done");
      psel <= 8'h3C;
      for (i = 0; i < 8; i++) begin
         wr8(FN, {i[0], 3'b011, 2'h0, i[2:1]});
         rdc(FN, {i[0], 5'h00, i[2:1]});
         idle(3);
         em = (i[2:1] == 2'h0) ? {2'h0, !i[0]} : {1'b0, i[2:1]} + 3'h1;
         chk({29'h0, mode}, {29'h0, em});
         chk({30'h0, xu, xm}, {30'h0, i[2:1] == 2'h2, i[2:1] == 2'h3});
      end
      wr8(FN, 8'hC0);
      extc <= 1'b1;
      idle(5);
      chk({31'h0, ext_o}, 32'h1);
      wr8(FN, 8'h80);
      idle(5);
      chk({31'h0, ext_o}, 32'h0);
      extc <= 1'b0;
      $display("mode test done");
      wr8(DS, 8'h11);
      wave <= 8'h5A;
      for (i = 0; i < 4; i++) begin
         wr8(FN, {4'h8, i[1:0], i[1] ? 2'h3 : 2'h1});
         idle(3);
         pm = ({8{i[1]}} & tmg_pkg::INV_PHASE_PINS) | ({8{i[0]}} & ~tmg_pkg::INV_PHASE_PINS);
         chk({24'h0, load}, {24'h0, ~(8'h5A ^ pm) & 8'hEE | 8'h11});
         chk({24'h0, oe}, 32'hEE);
      end
      $display("polarity test done");
      wr8(RN, 8'h03);
      idle(2);
      chk({30'h0, run1, run0}, 32'h3);
      evt <= 1'b1;
      @(posedge clk);
      evt <= 1'b0;
      idle(3);
      chk({24'h0, load}, 32'h11);
      rdc(CT, 8'h01);
      wr8(CT, 8'h00);
      rdc(CT, 8'h01);
      wr8(RN, 8'h00);
      wr8(CT, 8'h00);
      rdc(CT, 8'h00);
      idle(2);
      chk({30'h0, run1, run0}, 32'h0);
      chk({24'h0, load}, 32'h5B);
      wr8(FN, 8'h80);
      psel <= 8'h0F;
      wave <= 8'hFF;
      wr8(RN, 8'h01);
      wr8(CT, 8'h01);
      idle(2);
      rdc(CT, 8'h01);
      chk({24'h0, load}, 32'hF1);
      wr8(RN, 8'h00);
      wr8(CT, 8'h00);
      wr8(CT, 8'h80);
      trip <= 1'b1;
      idle(6);
      rdc(CT, 8'h81);
      trip <= 1'b0;
      idle(4);
      wr8(CT, 8'h80);
      rdc(CT, 8'h80);
      wr8(CT, 8'h00);
      trip <= 1'b1;
      idle(6);
      rdc(CT, 8'h00);
      trip <= 1'b0;
      $display("cutoff test done");
      tally_and_finish();
   end
endmodule
